// file: rtl/sfr_bank_status_pointers.v
// Special-function register core: pointers, bank select, accumulator, flags, watchdog.
// Assumes the core presents one access per cycle and waits out pc_stall.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_defs.vh"
module sfr_bank_status_pointers #(
	parameter PC_W    = 12,
	parameter WDT_W   = 8
) (
	input  wire            clk,
	input  wire            rst_n,
	input  wire            power_up,
	input  wire            asleep,
	input  wire            acc_en,
	input  wire            acc_wr,
	input  wire [7:0]      acc_addr,
	input  wire [7:0]      acc_wdata,
	output reg  [7:0]      acc_rdata,
	output reg             mem_we,
	output reg             mem_bank,
	output reg  [7:0]      mem_addr,
	output reg  [7:0]      mem_wdata,
	input  wire [7:0]      mem_rdata,
	output reg  [7:0]      eeprom_port_reg,
	input  wire            eeprom_data_out,
	input  wire            alu_en,
	input  wire [2:0]      alu_op,
	input  wire [7:0]      alu_operand,
	input  wire            alu_to_acc,
	input  wire            logic_zero_only,
	input  wire            pc_step,
	output reg  [PC_W-1:0] pc,
	output reg             pc_stall,
	input  wire            table_read,
	input  wire            table_last_page,
	input  wire [15:0]     table_word,
	output reg  [7:0]      table_low,
	input  wire            wdt_tick,
	input  wire            watchdog_clear_instruction,
	input  wire            sleep_instruction,
	output reg             wdt_reset,
	input  wire            irq_entry,
	input  wire            interrupt_return_instruction,
	input  wire            ext_irq_req,
	input  wire            tmr_irq_req,
	output reg             irq_ext_take,
	output reg             irq_tmr_take
);
	reg  [7:0] indirect_pointer_a;
	reg  [7:0] indirect_pointer_b;
	reg  [7:0] bank_select_reg;
	reg  [7:0] accumulator;
	reg  [7:0] table_pointer_reg;
	reg  [7:0] table_high_byte_reg;
	reg  [7:0] watchdog_divider_reg;
	reg  [7:0] irq_control_reg;
	reg  [5:0] flags_reg;
	wire       timeout;

	reg        use_a;
	reg        use_b;
	reg [7:0]  eff_addr;
	reg        eff_bank;
	reg        win_loop;
	reg        is_sfr;
	reg        is_eeprom;
	reg [7:0]  sfr_read;
	reg [8:0]  sum;
	reg [4:0]  nib;
	reg [7:0]  res;
	reg        c7;
	reg        next_carry;
	reg        next_half;
	reg        next_wrap;
	reg        arith;
	reg [7:0]  b_op;

	////////////////////////////////////////////////////////////////////////////////
	// Address resolution

	always @* begin
		use_a     = (acc_addr == `ADR_WINDOW_A);
		use_b     = (acc_addr == `ADR_WINDOW_B);
		eff_addr  = acc_addr;
		eff_bank  = 1'b0;
		if (use_a) begin
			eff_addr = indirect_pointer_a;
			eff_bank = 1'b0;
		end else if (use_b) begin
			eff_addr = indirect_pointer_b;
			eff_bank = bank_select_reg[0];
		end
		win_loop  = (use_a || use_b) &&
			(eff_addr == `ADR_WINDOW_A || eff_addr == `ADR_WINDOW_B);
		// Special area ignores the bank; the eeprom port is at 0x40 in bank 1 only, reached through window B
		is_sfr    = (eff_addr <= `ADR_SFR_LAST);
		is_eeprom = use_b && eff_bank && (eff_addr == `ADR_EEPROM_PORT);
	end

	always @* begin
		sfr_read = 8'h00;
		if (eff_addr == `ADR_POINTER_A)
			sfr_read = indirect_pointer_a;
		else if (eff_addr == `ADR_POINTER_B)
			sfr_read = indirect_pointer_b;
		else if (eff_addr == `ADR_BANK_SEL)
			sfr_read = bank_select_reg;
		else if (eff_addr == `ADR_ACC)
			sfr_read = accumulator;
		else if (eff_addr == `ADR_PC_LOW)
			sfr_read = pc[7:0];
		else if (eff_addr == `ADR_TBL_PTR)
			sfr_read = table_pointer_reg;
		else if (eff_addr == `ADR_TBL_HIGH)
			sfr_read = table_high_byte_reg;
		else if (eff_addr == `ADR_WDT_DIV)
			sfr_read = watchdog_divider_reg;
		else if (eff_addr == `ADR_FLAGS)
			sfr_read = {2'b00, flags_reg};
		else if (eff_addr == `ADR_IRQ_CTRL)
			sfr_read = irq_control_reg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alu flag arithmetic

	always @* begin
		b_op  = (alu_op == `ALU_SUB) ? ~alu_operand : alu_operand;
		// Subtract is a + ~b + 1, so carry out means no borrow
		sum   = {1'b0, accumulator} + {1'b0, b_op} + {8'h00, (alu_op == `ALU_SUB)};
		nib   = {1'b0, accumulator[3:0]} + {1'b0, b_op[3:0]} + {4'h0, (alu_op == `ALU_SUB)};
		c7    = accumulator[7] ^ b_op[7] ^ sum[7];
		arith = (alu_op == `ALU_ADD) || (alu_op == `ALU_SUB);
		next_carry = flags_reg[`FLG_CARRY];
		next_half  = flags_reg[`FLG_HALF];
		next_wrap  = flags_reg[`FLG_WRAP];
		case (alu_op)
			`ALU_ADD, `ALU_SUB: begin
				res        = sum[7:0];
				next_carry = sum[8];
				next_half  = nib[4];
				next_wrap  = c7 ^ sum[8];
			end
			`ALU_AND: res = accumulator & alu_operand;
			`ALU_OR:  res = accumulator | alu_operand;
			`ALU_XOR: res = accumulator ^ alu_operand;
			`ALU_RLC: begin
				res        = {alu_operand[6:0], flags_reg[`FLG_CARRY]};
				next_carry = alu_operand[7];
			end
			`ALU_RRC: begin
				res        = {flags_reg[`FLG_CARRY], alu_operand[7:1]};
				next_carry = alu_operand[0];
			end
			default: res = alu_operand;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			indirect_pointer_a   <= `RST_BYTE;
			indirect_pointer_b   <= `RST_BYTE;
			bank_select_reg      <= `RST_BYTE;
			accumulator          <= `RST_BYTE;
			table_pointer_reg    <= `RST_BYTE;
			table_high_byte_reg  <= `RST_BYTE;
			watchdog_divider_reg <= `RST_WDT_DIV;
			irq_control_reg      <= `RST_BYTE;
			flags_reg            <= 6'h00;
			eeprom_port_reg      <= `RST_BYTE;
			pc                   <= {PC_W{1'b0}};
			pc_stall             <= 1'b0;
			acc_rdata            <= `RST_BYTE;
			table_low            <= `RST_BYTE;
			wdt_reset            <= 1'b0;
			irq_ext_take         <= 1'b0;
			irq_tmr_take         <= 1'b0;
			mem_we               <= 1'b0;
			mem_bank             <= 1'b0;
			mem_addr             <= `RST_BYTE;
			mem_wdata            <= `RST_BYTE;
		end else begin
			// Watchdog reset during sleep keeps the bank; other resets clear it
			wdt_reset <= timeout && !asleep;
			mem_we    <= 1'b0;
			pc_stall  <= 1'b0;
			eeprom_port_reg[7] <= eeprom_data_out;
			if (pc_step && !pc_stall)
				pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
			if (power_up || (timeout && !asleep))
				bank_select_reg <= `RST_BYTE;
			if (acc_en && !acc_wr) begin
				if (win_loop)
					acc_rdata <= 8'h00;
				else if (is_eeprom)
					acc_rdata <= {eeprom_port_reg[7:4], 4'h0};
				else if (is_sfr)
					acc_rdata <= sfr_read;
				else
					acc_rdata <= mem_rdata;
			end
			if (acc_en && acc_wr && !win_loop) begin
				if (is_eeprom)
					eeprom_port_reg[6:4] <= acc_wdata[6:4];
				else if (!is_sfr) begin
					mem_we    <= 1'b1;
					mem_bank  <= eff_bank;
					mem_addr  <= eff_addr;
					mem_wdata <= acc_wdata;
				end else if (eff_addr == `ADR_POINTER_A)
					indirect_pointer_a <= acc_wdata;
				else if (eff_addr == `ADR_POINTER_B)
					indirect_pointer_b <= acc_wdata;
				else if (eff_addr == `ADR_BANK_SEL)
					bank_select_reg <= acc_wdata;
				else if (eff_addr == `ADR_ACC)
					accumulator <= acc_wdata;
				else if (eff_addr == `ADR_PC_LOW) begin
					pc       <= {pc[PC_W-1:8], acc_wdata};
					pc_stall <= 1'b1;
				end else if (eff_addr == `ADR_TBL_PTR)
					table_pointer_reg <= acc_wdata;
				else if (eff_addr == `ADR_WDT_DIV)
					watchdog_divider_reg <= acc_wdata;
				else if (eff_addr == `ADR_FLAGS)
					flags_reg[3:0] <= acc_wdata[3:0];
				else if (eff_addr == `ADR_IRQ_CTRL)
					irq_control_reg <= acc_wdata;
			end
			if (alu_en) begin
				if (alu_to_acc)
					accumulator <= res;
				if (!logic_zero_only || arith) begin
					flags_reg[`FLG_CARRY] <= next_carry;
					flags_reg[`FLG_HALF]  <= next_half;
					flags_reg[`FLG_WRAP]  <= next_wrap;
				end
				if (alu_op != `ALU_RLC && alu_op != `ALU_RRC && alu_op != `ALU_PASS)
					flags_reg[`FLG_ZERO] <= (res == 8'h00);
			end
			if (table_read) begin
				table_high_byte_reg <= table_word[15:8];
				table_low           <= table_word[7:0];
			end
			// Flags are never stacked; software saves them itself
			if (power_up || watchdog_clear_instruction)
				flags_reg[`FLG_SLEEP] <= 1'b0;
			else if (sleep_instruction)
				flags_reg[`FLG_SLEEP] <= 1'b1;
			if (timeout)
				flags_reg[`FLG_EXPIRED] <= 1'b1;
			else if (power_up || watchdog_clear_instruction || sleep_instruction)
				flags_reg[`FLG_EXPIRED] <= 1'b0;
			irq_ext_take <= irq_control_reg[`IRQ_GLOBAL] && irq_control_reg[`IRQ_EXT_EN]
				&& ext_irq_req && !irq_entry;
			irq_tmr_take <= irq_control_reg[`IRQ_GLOBAL] && irq_control_reg[`IRQ_TMR_EN]
				&& tmr_irq_req && !ext_irq_req && !irq_entry;
			if (irq_entry)
				irq_control_reg[`IRQ_GLOBAL] <= 1'b0;
			else if (interrupt_return_instruction)
				irq_control_reg[`IRQ_GLOBAL] <= 1'b1;
		end
	end

	watchdog_core #(
		.COUNT_W (WDT_W)
	) u_wdt (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (wdt_tick),
		.ratio   (watchdog_divider_reg[2:0]),
		.clear   (watchdog_clear_instruction || sleep_instruction || power_up),
		.timeout (timeout)
	);
endmodule
`default_nettype wire

// file: rtl/sfr_bank_defs.vh
// Constants for the special-function register bank: addresses, fields, resets.
// Assumes inclusion by bare name from the design files.
`ifndef SFR_BANK_DEFS_VH
`define SFR_BANK_DEFS_VH
`define ADR_WINDOW_A    8'h00
`define ADR_POINTER_A   8'h01
`define ADR_WINDOW_B    8'h02
`define ADR_POINTER_B   8'h03
`define ADR_BANK_SEL    8'h04
`define ADR_ACC         8'h05
`define ADR_PC_LOW      8'h06
`define ADR_TBL_PTR     8'h07
`define ADR_TBL_HIGH    8'h08
`define ADR_WDT_DIV     8'h09
`define ADR_FLAGS       8'h0a
`define ADR_IRQ_CTRL    8'h0b
`define ADR_SFR_LAST    8'h1f
`define ADR_EEPROM_PORT 8'h40
`define FLG_CARRY       0
`define FLG_HALF        1
`define FLG_ZERO        2
`define FLG_WRAP        3
`define FLG_SLEEP       4
`define FLG_EXPIRED     5
`define IRQ_GLOBAL      0
`define IRQ_EXT_EN      1
`define IRQ_TMR_EN      2
`define RST_BYTE        8'h00
`define RST_WDT_DIV     8'h07
`define ALU_ADD         3'h0
`define ALU_SUB         3'h1
`define ALU_AND         3'h2
`define ALU_OR          3'h3
`define ALU_XOR         3'h4
`define ALU_RLC         3'h5
`define ALU_RRC         3'h6
`define ALU_PASS        3'h7
`endif

// file: rtl/watchdog_core.v
// Watchdog: prescaler selected by a 3-bit ratio and an overflow counter.
// Assumes a one-cycle tick enable from the watchdog clock source, same clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_defs.vh"
module watchdog_core #(
	parameter COUNT_W = 8
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       tick,
	input  wire [2:0] ratio,
	input  wire       clear,
	output reg        timeout
);
	reg [6:0]         prescale;
	reg [COUNT_W-1:0] count;
	wire              div_hit;

	// Ratio n divides by 2^n, so 0 gives 1 and 7 gives 128
	assign div_hit = tick && ((prescale | ~((7'h01 << ratio) - 7'h01)) == 7'h7f);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 7'h00;
			count    <= {COUNT_W{1'b0}};
			timeout  <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (clear) begin
				prescale <= 7'h00;
				count    <= {COUNT_W{1'b0}};
			end else if (tick) begin
				prescale <= div_hit ? 7'h00 : prescale + 7'h01;
				if (div_hit) begin
					count <= count + {{(COUNT_W-1){1'b0}}, 1'b1};
					if (&count)
						timeout <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/sfr_bank_chk_sva.sv
// Port checker for the register core.
// Bound from the bench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_chk #(
	parameter PC_W = 12
) (
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            asleep,
	input wire logic            acc_en,
	input wire logic            acc_wr,
	input wire logic [7:0]      acc_addr,
	input wire logic [7:0]      acc_wdata,
	input wire logic [7:0]      acc_rdata,
	input wire logic            mem_we,
	input wire logic            mem_bank,
	input wire logic [7:0]      mem_addr,
	input wire logic [7:0]      eeprom_port_reg,
	input wire logic            eeprom_data_out,
	input wire logic [PC_W-1:0] pc,
	input wire logic            pc_stall,
	input wire logic            wdt_reset,
	input wire logic            ext_irq_req,
	input wire logic            irq_ext_take
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence pcl_wr;
		acc_en && acc_wr && acc_addr == 8'h06;
	endsequence
	sequence jump_in_page;
		pc_stall && pc[7:0] == $past(acc_wdata) && pc[PC_W-1:8] == $past(pc[PC_W-1:8]);
	endsequence
	a_pcl_jump: assert property (pcl_wr |=> jump_in_page)
		else $error("pc low write gave no in-page jump");
	a_stall_cause: assert property (pc_stall |-> $past(acc_en && acc_wr && acc_addr == 8'h06))
		else $error("stall without pc low write");
	a_direct_bank0: assert property (acc_en && acc_wr && acc_addr >= 8'h20 |=>
		mem_we && !mem_bank && mem_addr == $past(acc_addr)) else $error("direct write not bank 0");
	a_sfr_no_ram: assert property (acc_en && acc_wr &&
		acc_addr inside {8'h01, [8'h03:8'h1f]} |=> !mem_we) else $error("sfr write reached ram");
	a_unused_zero: assert property (acc_en && !acc_wr &&
		acc_addr inside {[8'h0c:8'h1f]} |=> acc_rdata == 8'h00) else $error("unused read not zero");
	a_port_low_zero: assert property (eeprom_port_reg[3:0] == 4'h0)
		else $error("port low bits not zero");
	a_port_do_follow: assert property (eeprom_port_reg[7] == $past(eeprom_data_out))
		else $error("port data bit does not follow input");
	a_wdt_awake: assert property (wdt_reset |-> !$past(asleep))
		else $error("watchdog reset while asleep");
	a_irq_ext_cause: assert property (irq_ext_take |-> $past(ext_irq_req))
		else $error("external take without request");
	a_mem_cause: assert property (mem_we |-> $past(acc_en && acc_wr))
		else $error("ram write without access");
endmodule
`default_nettype wire

// file: testbench/ram_model.sv
// Partner RAM: two banks of general data memory.
// Assumes single-cycle write strobes on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ram_model (
	input  wire logic       clk,
	input  wire logic       mem_we,
	input  wire logic       mem_bank,
	input  wire logic [7:0] mem_addr,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata
);
	logic [7:0] ram [0:511];
	initial begin
		for (int i = 0; i < 512; i++) begin
			ram[i] = 8'h00;
		end
	end
	always @(posedge clk) begin
		if (mem_we) begin
			ram[{mem_bank, mem_addr}] <= mem_wdata;
		end
	end
	// Bank bit picks the upper half
	assign mem_rdata = ram[{mem_bank, mem_addr}];
endmodule
`default_nettype wire

// file: testbench/test_sfr_bank_status_pointers.sv
// Self-checking bench for the register core.
// Assumes the design defines header and the RAM partner.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_bank_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_sfr_bank_status_pointers;
	logic        clk = 1'b0;
	logic        rst_n, acc_en, acc_wr, eeprom_data_out, wdt_tick, ext_irq_req, tmr_irq_req;
	logic        asleep;
	logic [7:0]  acc_addr, acc_wdata, alu_operand, d, ev;
	logic [2:0]  alu_op;
	logic [15:0] table_word;
	wire  [7:0]  acc_rdata, mem_addr, mem_wdata, mem_rdata, eeprom_port_reg, table_low;
	wire  [11:0] pc;
	wire         mem_we, mem_bank, pc_stall, wdt_reset, irq_ext_take, irq_tmr_take;
	int          bad_count = 0;
	int          compares = 0;
	always #2.5 clk = ~clk;
	sfr_bank_status_pointers #(.WDT_W(2)) u_sfr_bank_status_pointers (
		.clk, .rst_n, .power_up(ev[6]), .asleep, .acc_en, .acc_wr, .acc_addr,
		.acc_wdata, .acc_rdata, .mem_we, .mem_bank, .mem_addr, .mem_wdata, .mem_rdata,
		.eeprom_port_reg, .eeprom_data_out, .alu_en(ev[0]), .alu_op, .alu_operand,
		.alu_to_acc(1'b1), .logic_zero_only(1'b0), .pc_step(ev[7]), .pc, .pc_stall,
		.table_read(ev[1]), .table_last_page(1'b0), .table_word, .table_low, .wdt_tick,
		.watchdog_clear_instruction(ev[3]), .sleep_instruction(ev[2]), .wdt_reset,
		.irq_entry(ev[4]), .interrupt_return_instruction(ev[5]), .ext_irq_req,
		.tmr_irq_req, .irq_ext_take, .irq_tmr_take);
	ram_model u_ram_model (.clk, .mem_we, .mem_bank, .mem_addr, .mem_wdata, .mem_rdata);
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		acc_en <= 1'b1;
		acc_wr <= 1'b1;
		acc_addr <= a;
		acc_wdata <= v;
		@(posedge clk);
		acc_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		acc_en <= 1'b1;
		acc_wr <= 1'b0;
		acc_addr <= a;
		@(posedge clk);
		acc_en <= 1'b0;
		@(posedge clk);
		#1;
		d = acc_rdata;
	endtask
	// One-cycle event strobes share one vector
	task automatic strobe(input logic [7:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 8'h00;
	endtask
	task automatic alu(input logic [2:0] op, input logic [7:0] v);
		alu_op <= op;
		alu_operand <= v;
		strobe(8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_ptr;
		wr(8'h04, 8'h01);
		wr(8'h60, 8'ha5);
		wr(8'h01, 8'h61);
		wr(8'h00, 8'h3c);
		wr(8'h03, 8'h61);
		wr(8'h02, 8'hc3);
		wr(8'h04, 8'h02);
		wr(8'h03, 8'h62);
		wr(8'h02, 8'h11);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h77);
		rd(8'h02);
		`CHK("loop rd", 8'h00, d)
		rd(8'h0c);
		`CHK("unused", 8'h00, d)
		`CHK("direct", 8'ha5, u_ram_model.ram[9'h060])
		`CHK("ptr a", 8'h3c, u_ram_model.ram[9'h061])
		`CHK("ptr b", 8'hc3, u_ram_model.ram[9'h161])
		`CHK("bank bit", 8'h11, u_ram_model.ram[9'h062])
		`CHK("loop wr", 8'h00, u_ram_model.ram[9'h000])
		$display("test pointers done");
	endtask
	task automatic t_eep;
		@(posedge clk);
		eeprom_data_out <= 1'b1;
		wr(8'h04, 8'h01);
		wr(8'h03, 8'h40);
		wr(8'h02, 8'h70);
		rd(8'h02);
		`CHK("port rd", 8'hf0, d)
		`CHK("port pins", 8'hf0, eeprom_port_reg)
		`CHK("port ram", 8'h00, u_ram_model.ram[9'h140])
		$display("test eeprom port done");
	endtask
	task automatic t_alu;
		wr(8'h05, 8'h7f);
		alu(`ALU_ADD, 8'h01);
		rd(8'h0a);
		`CHK("add flags", 8'h0a, d)
		rd(8'h05);
		`CHK("acc", 8'h80, d)
		alu(`ALU_ADD, 8'h80);
		rd(8'h0a);
		`CHK("carry flags", 8'h0d, d)
		alu(`ALU_RLC, 8'h00);
		rd(8'h05);
		`CHK("rotate", 8'h01, d)
		rd(8'h0a);
		`CHK("rot flags", 8'h0c, d)
		$display("test alu done");
	endtask
	task automatic t_flg;
		wr(8'h0a, 8'hff);
		rd(8'h0a);
		`CHK("flag wr", 8'h0f, d)
		strobe(8'h04);
		rd(8'h0a);
		`CHK("sleep", 8'h1f, d)
		strobe(8'h08);
		rd(8'h0a);
		`CHK("wdt clr", 8'h0f, d)
		$display("test flags done");
	endtask
	task automatic t_pct;
		wr(8'h06, 8'ha5);
		repeat (2) @(posedge clk);
		#1;
		`CHK("pc", 12'h0a5, pc)
		table_word <= 16'h1234;
		strobe(8'h02);
		rd(8'h08);
		`CHK("tbl high", 8'h12, d)
		`CHK("tbl low", 8'h34, table_low)
		$display("test pc table done");
	endtask
	task automatic t_irq;
		wr(8'h0b, 8'h03);
		ext_irq_req <= 1'b1;
		tmr_irq_req <= 1'b1;
		rd(8'h0b);
		`CHK("ext take", 1'b1, irq_ext_take)
		`CHK("tmr take", 1'b0, irq_tmr_take)
		strobe(8'h10);
		rd(8'h0b);
		`CHK("entry", 8'h02, d)
		`CHK("gated", 1'b0, irq_ext_take)
		strobe(8'h20);
		rd(8'h0b);
		`CHK("return", 8'h03, d)
		ext_irq_req <= 1'b0;
		wr(8'h0b, 8'h05);
		rd(8'h0b);
		`CHK("tmr take on", 1'b1, irq_tmr_take)
		`CHK("ext take off", 1'b0, irq_ext_take)
		tmr_irq_req <= 1'b0;
		$display("test irq done");
	endtask
	task automatic t_wdt;
		wr(8'h04, 8'h01);
		wr(8'h09, 8'h00);
		wdt_tick <= 1'b1;
		for (int i = 0; i < 100 && wdt_reset !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("wdt reset", 1'b1, wdt_reset)
		wdt_tick <= 1'b0;
		rd(8'h0a);
		`CHK("expired", 1'b1, d[5])
		rd(8'h04);
		`CHK("bank rst", 8'h00, d)
		strobe(8'h40);
		rd(8'h0a);
		`CHK("power up", 1'b0, d[5])
		// Time-out while asleep: no reset pulse and the bank is kept
		wr(8'h04, 8'h01);
		@(posedge clk);
		asleep <= 1'b1;
		wdt_tick <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1;
			`CHK("sleep rst", 1'b0, wdt_reset)
		end
		wdt_tick <= 1'b0;
		asleep <= 1'b0;
		rd(8'h04);
		`CHK("bank kept", 8'h01, d)
		rd(8'h0a);
		`CHK("sleep expired", 1'b1, d[5])
		$display("test watchdog done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{rst_n, acc_en, acc_wr, eeprom_data_out, wdt_tick, ext_irq_req, tmr_irq_req} = '0;
		asleep = 1'b0;
		{acc_addr, acc_wdata, alu_operand, ev, alu_op, table_word} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h0a);
		`CHK("flags rst", 8'h00, d)
		rd(8'h09);
		`CHK("div rst", 8'h07, d)
		t_ptr();
		t_eep();
		t_alu();
		t_flg();
		t_pct();
		t_irq();
		t_wdt();
		end_sim();
	end
	// A hang costs far more than the fewer than two hundred cycles the tests need
	initial begin
		#10000;
		bad_count++;
		end_sim();
	end
endmodule
bind sfr_bank_status_pointers sfr_bank_chk #(.PC_W(PC_W)) u_sfr_bank_chk (
	.clk, .rst_n, .asleep, .acc_en, .acc_wr, .acc_addr, .acc_wdata, .acc_rdata,
	.mem_we, .mem_bank, .mem_addr, .eeprom_port_reg, .eeprom_data_out, .pc, .pc_stall,
	.wdt_reset, .ext_irq_req, .irq_ext_take);
`default_nettype wire
